// >>> core/afc_bp_timer.sv
// Back-pressure duration timer, reloadable at any time
`timescale 1ns/1ns
module afc_bp_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] load_cycles,
  // Status
  output logic busy
);
  logic [CNT_W-1:0] remaining;

  // A reload in the middle of a jam restarts the full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining <= '0;
    end else if (load) begin
      remaining <= load_cycles;
    end else if (remaining != '0) begin
      remaining <= remaining - 1'b1;
    end
  end

  assign busy = (remaining != '0);
endmodule : afc_bp_timer

// >>> core/afc_core.sv
// Receive auto flow control: APB registers, half-duplex jamming, full-duplex pause requests
`timescale 1ns/1ns
module afc_core #(
  parameter int LVL_W = 14,
  parameter int CNT_W = 16,
  parameter int unsigned CLK_NS = afc_pkg::AFC_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // MAC and link status
  input wire logic full_duplex,
  input wire logic speed_100,
  input wire logic tx_enabled,
  input wire logic [LVL_W-1:0] rx_fifo_level,
  // Receive frame events
  input wire logic rx_preamble,
  input wire logic rx_addr_valid,
  input wire logic rx_is_multicast,
  input wire logic rx_is_broadcast,
  input wire logic rx_addr_match,
  // Transmitter requests
  output logic backpressure,
  output logic pause_req,
  output logic pause_zero,
  input wire logic pause_ack
);
  import afc_pkg::*;

  logic [31:0] auto_flow_control_config;
  logic [7:0] high_water_level;
  logic [7:0] low_water_level;
  logic [3:0] backpressure_duration;
  logic trigger_on_multicast;
  logic trigger_on_broadcast;
  logic trigger_on_address_match;
  logic trigger_on_any_frame;
  logic above_hi;
  logic below_lo;
  logic half_ok;
  logic frame_match;
  logic bp_load;
  logic bp_busy;
  logic [CNT_W-1:0] bp_cycles;
  logic [31:0] status_word;
  logic setup;
  logic wr_cfg;
  afc_fd_state_t fd_state;
  afc_fd_state_t next_fd_state;

  assign high_water_level = auto_flow_control_config[AFC_HIGH_LSB +: 8];
  assign low_water_level = auto_flow_control_config[AFC_LOW_LSB +: 8];
  assign backpressure_duration = auto_flow_control_config[AFC_DUR_LSB +: 4];
  assign trigger_on_multicast = auto_flow_control_config[AFC_MULT_BIT];
  assign trigger_on_broadcast = auto_flow_control_config[AFC_BRD_BIT];
  assign trigger_on_address_match = auto_flow_control_config[AFC_ADDR_BIT];
  assign trigger_on_any_frame = auto_flow_control_config[AFC_ANY_BIT];

  // APB: zero wait states, read data captured in the setup cycle
  assign setup = psel && !penable;
  assign wr_cfg = psel && penable && pwrite && (paddr == AFC_CONFIG_ADDR);
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_flow_control_config <= AFC_CONFIG_RESET;
    end else if (wr_cfg) begin
      auto_flow_control_config <= pwdata & AFC_CONFIG_WMASK;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[AFC_ST_BP_BIT] = backpressure;
    status_word[AFC_ST_REQ_BIT] = pause_req;
    status_word[AFC_ST_HI_BIT] = above_hi;
    status_word[AFC_ST_PAUSED_BIT] = (fd_state == FD_PAUSED);
    status_word[AFC_ST_LO_BIT] = below_lo;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= (paddr != AFC_CONFIG_ADDR) && (paddr != AFC_STAT_ADDR);
      if (pwrite) begin
        prdata <= '0;
      end else if (paddr == AFC_CONFIG_ADDR) begin
        prdata <= auto_flow_control_config;
      end else if (paddr == AFC_STAT_ADDR) begin
        prdata <= status_word;
      end else begin
        prdata <= '0;
      end
    end
  end

  // Thresholds in 64-byte units
  assign above_hi = rx_fifo_level >= LVL_W'({high_water_level, 6'h00});
  assign below_lo = rx_fifo_level < LVL_W'({low_water_level, 6'h00});

  // Half duplex: any-frame jams on preamble; otherwise a decoded address must match an enabled class
  assign half_ok = !full_duplex && tx_enabled && above_hi;
  assign frame_match = rx_addr_valid && ((trigger_on_multicast && rx_is_multicast)
                       || (trigger_on_broadcast && rx_is_broadcast)
                       || (trigger_on_address_match && rx_addr_match));
  assign bp_load = half_ok && (trigger_on_any_frame ? rx_preamble : frame_match);

  assign bp_cycles = CNT_W'(afc_bp_cycles(backpressure_duration, speed_100, CLK_NS));

  afc_bp_timer #(
    .CNT_W(CNT_W)
  ) u_bp_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(bp_load),
    .load_cycles(bp_cycles),
    .busy(bp_busy)
  );

  // Duration is meaningless in full duplex, so the jam is masked there
  assign backpressure = bp_busy && !full_duplex && tx_enabled;

  // Full duplex pause sequencing; leaving full duplex or clearing any-frame abandons it
  always_comb begin
    next_fd_state = fd_state;
    if (!full_duplex || !trigger_on_any_frame) begin
      next_fd_state = FD_IDLE;
    end else begin
      case (fd_state)
        FD_IDLE: begin
          if (above_hi && tx_enabled) begin
            next_fd_state = FD_SEND_HI;
          end
        end
        FD_SEND_HI: begin
          if (pause_ack && tx_enabled) begin
            next_fd_state = FD_PAUSED;
          end
        end
        FD_PAUSED: begin
          if (below_lo) begin
            next_fd_state = FD_SEND_ZERO;
          end
        end
        FD_SEND_ZERO: begin
          if (pause_ack && tx_enabled) begin
            next_fd_state = FD_IDLE;
          end
        end
        default: begin
          next_fd_state = FD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fd_state <= FD_IDLE;
    end else begin
      fd_state <= next_fd_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_zero <= 1'b0;
    end else begin
      pause_zero <= (next_fd_state == FD_SEND_ZERO);
    end
  end

  // Request withheld, not dropped, while the transmitter is off
  assign pause_req = ((fd_state == FD_SEND_HI) || (fd_state == FD_SEND_ZERO)) && tx_enabled;

  // Helper: length of each jam run since its last load
  logic [CNT_W-1:0] bp_run;
  logic [CNT_W-1:0] bp_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bp_run <= '0;
      bp_len <= '0;
    end else if (bp_load) begin
      bp_run <= '0;
      bp_len <= bp_cycles;
    end else if (bp_busy) begin
      bp_run <= bp_run + 1'b1;
    end
  end

  a_fd_no_jam: assert property (@(posedge pclk) disable iff (!presetn)
    full_duplex |-> !backpressure) else $error("jam driven in full duplex");

  a_txoff_silent: assert property (@(posedge pclk) disable iff (!presetn)
    !tx_enabled |-> !backpressure && !pause_req) else $error("activity with transmitter off");

  a_any_preamble_jam: assert property (@(posedge pclk) disable iff (!presetn)
    half_ok && trigger_on_any_frame && rx_preamble ##1 (!full_duplex && tx_enabled) |-> backpressure)
    else $error("preamble did not start jam");

  a_mcast_jam: assert property (@(posedge pclk) disable iff (!presetn)
    half_ok && !trigger_on_any_frame && trigger_on_multicast && rx_addr_valid && rx_is_multicast
    ##1 (!full_duplex && tx_enabled) |-> backpressure) else $error("multicast did not jam");

  a_bcast_jam: assert property (@(posedge pclk) disable iff (!presetn)
    half_ok && !trigger_on_any_frame && trigger_on_broadcast && rx_addr_valid && rx_is_broadcast
    ##1 (!full_duplex && tx_enabled) |-> backpressure) else $error("broadcast did not jam");

  a_match_jam: assert property (@(posedge pclk) disable iff (!presetn)
    half_ok && !trigger_on_any_frame && trigger_on_address_match && rx_addr_valid && rx_addr_match
    ##1 (!full_duplex && tx_enabled) |-> backpressure) else $error("address match did not jam");

  a_any_overrides: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bp_busy) && $past(trigger_on_any_frame) |-> $past(rx_preamble))
    else $error("jam started without preamble in any-frame mode");

  a_jam_length: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(bp_busy) |-> $past(bp_run) + 1'b1 == bp_len) else $error("jam length wrong");

  a_dur_code0: assert property (@(posedge pclk) disable iff (!presetn)
    backpressure_duration == 4'h0 && speed_100 |-> bp_cycles == CNT_W'((5000 + CLK_NS - 1) / CLK_NS))
    else $error("5 us code wrong");

  a_dur_10m: assert property (@(posedge pclk) disable iff (!presetn)
    backpressure_duration == 4'hF && !speed_100 |-> bp_cycles == CNT_W'((602200 + CLK_NS - 1) / CLK_NS))
    else $error("602.2 us code wrong");

  a_pause_prompt: assert property (@(posedge pclk) disable iff (!presetn)
    fd_state == FD_IDLE && full_duplex && trigger_on_any_frame && above_hi && tx_enabled
    ##1 (full_duplex && trigger_on_any_frame && tx_enabled) |-> pause_req && !pause_zero)
    else $error("pause not requested at high level");

  a_hi_cause: assert property (@(posedge pclk) disable iff (!presetn)
    fd_state == FD_SEND_HI && $past(fd_state) == FD_IDLE |-> $past(above_hi))
    else $error("pause without high level");

  a_zero_cause: assert property (@(posedge pclk) disable iff (!presetn)
    fd_state == FD_SEND_ZERO && $past(fd_state) != FD_SEND_ZERO |-> $past(fd_state) == FD_PAUSED
    && $past(below_lo) && pause_zero) else $error("zero pause without prior pause");

  c_hd_any_jam: cover property (@(posedge pclk) disable iff (!presetn)
    trigger_on_any_frame && $rose(backpressure));
  c_hd_mcast_jam: cover property (@(posedge pclk) disable iff (!presetn)
    !trigger_on_any_frame && rx_is_multicast && bp_load);
  c_fd_pause_hi: cover property (@(posedge pclk) disable iff (!presetn)
    pause_req && !pause_zero && pause_ack);
  c_fd_pause_zero: cover property (@(posedge pclk) disable iff (!presetn)
    pause_req && pause_zero && pause_ack);
endmodule : afc_core

// >>> core/afc_pkg.sv
// Constants, types and duration lookup for the receive auto flow control block
// Summary of operation
// - Automatic back pressure is held for the period chosen by the duration field in bits 7:4.
// - In full duplex the duration field has no effect at all.
// - In half duplex the multicast enable in bit 3 jams multicast frames once the high level is reached.
// - In half duplex the broadcast enable in bit 2 jams broadcast frames once the high level is reached.
// - In half duplex the address-match enable in bit 1 jams frames addressed to us once the high level is reached.
// - The any-frame enable in bit 0 triggers back pressure or a pause frame and alone enables full-duplex pausing.
// - With any-frame in half duplex, no address decode is needed: a valid preamble after the high level jams.
// - With any-frame in full duplex, a pause frame is requested as soon as the high level is reached.
// - While any-frame is set the multicast, broadcast and address-match enables are ignored.
// - Duration codes map to 5, 10, 15, 25, then 50 to 600 us in 50 us steps at 100 Mb/s, plus 2.2 us at 10 Mb/s.
// - The high-water level counts receive FIFO occupancy in units of 64 bytes.
// - After a pause frame at the high level, a zero-time pause is sent once occupancy falls below bits 15:8.
// - In half duplex, back pressure jams each matching incoming frame for the chosen duration.
// - Nothing is paused or jammed while the transmitter is disabled.
package afc_pkg;
  localparam logic [7:0] AFC_CONFIG_ADDR = 8'hAC;
  localparam logic [7:0] AFC_STAT_ADDR = 8'hC0;
  localparam logic [31:0] AFC_CONFIG_RESET = 32'h00000000;
  localparam logic [31:0] AFC_CONFIG_WMASK = 32'h00FFFFFF;
  localparam int AFC_HIGH_LSB = 16;
  localparam int AFC_LOW_LSB = 8;
  localparam int AFC_DUR_LSB = 4;
  localparam int AFC_MULT_BIT = 3;
  localparam int AFC_BRD_BIT = 2;
  localparam int AFC_ADDR_BIT = 1;
  localparam int AFC_ANY_BIT = 0;
  localparam int AFC_UNIT_SHIFT = 6;
  localparam int AFC_ST_BP_BIT = 0;
  localparam int AFC_ST_REQ_BIT = 1;
  localparam int AFC_ST_HI_BIT = 2;
  localparam int AFC_ST_PAUSED_BIT = 3;
  localparam int AFC_ST_LO_BIT = 4;
  localparam int unsigned AFC_CLK_PERIOD_NS = 100;
  localparam int unsigned AFC_BP_FIRST_NS = 5000;
  localparam int unsigned AFC_BP_CODE3_NS = 25000;
  localparam int unsigned AFC_BP_STEP_NS = 50000;
  localparam int unsigned AFC_BP_10M_EXTRA_NS = 2200;

  typedef enum logic [3:0] {
    FD_IDLE = 4'h1,
    FD_SEND_HI = 4'h2,
    FD_PAUSED = 4'h4,
    FD_SEND_ZERO = 4'h8
  } afc_fd_state_t;

  function automatic int unsigned afc_bp_ns(input logic [3:0] code, input logic speed_100);
    int unsigned ns;
    if (code < 4'h3) begin
      ns = AFC_BP_FIRST_NS * (int'(code) + 1);
    end else if (code == 4'h3) begin
      ns = AFC_BP_CODE3_NS;
    end else begin
      ns = AFC_BP_STEP_NS * (int'(code) - 3);
    end
    if (!speed_100) begin
      ns = ns + AFC_BP_10M_EXTRA_NS;
    end
    return ns;
  endfunction : afc_bp_ns

  // Least time, so round up; never below one cycle
  function automatic int unsigned afc_bp_cycles(input logic [3:0] code, input logic speed_100,
                                                input int unsigned clk_ns);
    int unsigned cyc;
    cyc = (afc_bp_ns(code, speed_100) + clk_ns - 1) / clk_ns;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc;
  endfunction : afc_bp_cycles
endpackage : afc_pkg

// >>> verif/afc_mac_model.sv
// MAC transmitter model that accepts pause frame requests from the flow controller
`timescale 1ns/1ns
module afc_mac_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request side
  input wire logic pause_req,
  input wire logic tx_enabled,
  input wire logic [3:0] ack_delay,
  // Answer
  output logic pause_ack
);
  logic [3:0] wait_cnt;

  // A pause waits for the next transmit window, modelled as ack_delay idle cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      pause_ack <= 1'b0;
    end else begin
      pause_ack <= 1'b0;
      if (!pause_req || !tx_enabled || pause_ack) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt >= ack_delay) begin
        pause_ack <= 1'b1;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : afc_mac_model

// >>> verif/rx_auto_flow_control_tb_top.sv
// Self-checking bench for the receive auto flow control block
`timescale 1ns/1ns
module rx_auto_flow_control_tb_top;
  import afc_pkg::*;
  // Raised clock figure shortens jam counts to at most 61 cycles
  localparam int TB_CLK_NS = 10000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er, full_duplex, speed_100, tx_enabled, rx_preamble, rx_addr_valid;
  logic rx_is_multicast, rx_is_broadcast, rx_addr_match, backpressure, pause_req, pause_zero, pause_ack;
  logic [13:0] rx_fifo_level;
  logic [3:0] ack_delay;
  logic [3:0] codes [4] = '{4'h0, 4'h3, 4'h4, 4'hF};
  int us [4] = '{5, 25, 50, 600};
  int fails = 0;
  int check_count = 0;

  afc_core #(.LVL_W(14), .CNT_W(16), .CLK_NS(TB_CLK_NS)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .full_duplex(full_duplex), .speed_100(speed_100), .tx_enabled(tx_enabled),
    .rx_fifo_level(rx_fifo_level), .rx_preamble(rx_preamble), .rx_addr_valid(rx_addr_valid),
    .rx_is_multicast(rx_is_multicast), .rx_is_broadcast(rx_is_broadcast), .rx_addr_match(rx_addr_match),
    .backpressure(backpressure), .pause_req(pause_req), .pause_zero(pause_zero), .pause_ack(pause_ack));
  afc_mac_model mac_u (.pclk(pclk), .presetn(presetn), .pause_req(pause_req), .tx_enabled(tx_enabled),
    .ack_delay(ack_delay), .pause_ack(pause_ack));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    wrap_up();
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      fails++;
      $display("Error pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Pulse frame events, then count the cycles that back pressure stands
  task automatic jam(input logic p, input logic a, input int exp, input string nm);
    int n;
    n = 0;
    @(posedge pclk);
    rx_preamble <= p;
    rx_addr_valid <= a;
    @(posedge pclk);
    rx_preamble <= 1'b0;
    rx_addr_valid <= 1'b0;
    #1;
    while (backpressure === 1'b1 && n < 10000) begin
      n++;
      @(posedge pclk);
      #1;
    end
    chk(nm, exp, n);
  endtask : jam

  task automatic wait_pause(input logic lvl);
    int n;
    n = 0;
    while (pause_req !== lvl && n < 50) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("pause request", {31'h0, lvl}, {31'h0, pause_req});
  endtask : wait_pause

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, full_duplex, rx_preamble, rx_addr_valid} = '0;
    {rx_is_multicast, rx_is_broadcast, rx_addr_match, ack_delay} = '0;
    {speed_100, tx_enabled} = 2'b11;
    rx_fifo_level = 14'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(AFC_CONFIG_ADDR, 1'b0, 32'h0);
    chk("config reset", 32'h00000000, rd);
    apb(AFC_CONFIG_ADDR, 1'b1, 32'hFFFFFFFF);
    apb(AFC_CONFIG_ADDR, 1'b0, 32'h0);
    chk("config readback", 32'h00FFFFFF, rd);
    // Levels at FFh with an empty FIFO: only the below-low flag may stand
    apb(AFC_STAT_ADDR, 1'b0, 32'h0);
    chk("status idle", 32'h00000010, rd);
    chk("status error", 32'h0, {31'h0, er});
    apb(8'hF0, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    $display("Test registers done");
    // Software keeps low below high: high 64 bytes, low 0
    rx_fifo_level <= 14'h0040;
    for (int s = 1; s >= 0; s--) begin
      for (int k = 0; k < 4; k++) begin
        speed_100 <= s[0];
        apb(AFC_CONFIG_ADDR, 1'b1, {16'h0001, 8'h00, codes[k], 4'h1});
        jam(1'b1, 1'b0, (us[k] * 1000 + (s == 1 ? 0 : 2200) + TB_CLK_NS - 1) / TB_CLK_NS, "jam length");
      end
    end
    speed_100 <= 1'b1;
    apb(AFC_CONFIG_ADDR, 1'b1, 32'h00010041);
    jam(1'b1, 1'b0, 5, "jam code 4");
    // Second trigger lands with two cycles left, so only a restart gives the full count
    @(posedge pclk);
    rx_preamble <= 1'b1;
    @(posedge pclk);
    rx_preamble <= 1'b0;
    repeat (2) @(posedge pclk);
    jam(1'b1, 1'b0, 5, "jam restart");
    rx_fifo_level <= 14'h003F;
    jam(1'b1, 1'b0, 0, "below high level");
    rx_fifo_level <= 14'h0040;
    tx_enabled <= 1'b0;
    jam(1'b1, 1'b0, 0, "tx disabled");
    repeat (10) @(posedge pclk);
    tx_enabled <= 1'b1;
    $display("Test half duplex any frame done");
    for (int i = 0; i < 3; i++) begin
      apb(AFC_CONFIG_ADDR, 1'b1, {16'h0001, 8'h00, 4'h0, 4'b1000 >> i});
      {rx_is_multicast, rx_is_broadcast, rx_addr_match} <= 3'b100 >> i;
      jam(1'b0, 1'b1, 1, "class match");
      {rx_is_multicast, rx_is_broadcast, rx_addr_match} <= (i == 2) ? 3'b100 : (3'b100 >> (i + 1));
      jam(1'b0, 1'b1, 0, "class mismatch");
    end
    apb(AFC_CONFIG_ADDR, 1'b1, 32'h0001000F);
    jam(1'b0, 1'b1, 0, "any ignores classes");
    jam(1'b1, 1'b0, 1, "any on preamble");
    $display("Test half duplex classes done");
    // Clear any-frame before entering full duplex so no stray pause starts
    apb(AFC_CONFIG_ADDR, 1'b1, 32'h000201FE);
    full_duplex <= 1'b1;
    ack_delay <= 4'h3;
    rx_fifo_level <= 14'h0080;
    jam(1'b1, 1'b1, 0, "full duplex classes");
    chk("no pause without any", 32'h0, {31'h0, pause_req});
    rx_fifo_level <= 14'h0000;
    apb(AFC_CONFIG_ADDR, 1'b1, 32'h000201F1);
    @(posedge pclk);
    rx_fifo_level <= 14'h0080;
    @(posedge pclk);
    #1;
    chk("pause at high", 32'h1, {31'h0, pause_req});
    chk("pause time nonzero", 32'h0, {31'h0, pause_zero});
    chk("no jam in full duplex", 32'h0, {31'h0, backpressure});
    wait_pause(1'b0);
    rx_fifo_level <= 14'h0040;
    repeat (5) @(posedge pclk);
    #1;
    chk("no zero pause at low", 32'h0, {31'h0, pause_req});
    rx_fifo_level <= 14'h003F;
    wait_pause(1'b1);
    chk("zero pause", 32'h1, {31'h0, pause_zero});
    wait_pause(1'b0);
    $display("Test full duplex pause done");
    wrap_up();
  end
endmodule : rx_auto_flow_control_tb_top
